// [pkg/alarm_pkg.sv]
package alarm_pkg;
   // ------------------------------------------------------------
   // Alarm register bit positions
   // ------------------------------------------------------------
   localparam int BIT_PWR   = 0;
   localparam int BIT_WDT   = 1;
   localparam int BIT_LOCK  = 2;
   localparam int BIT_MEM   = 3;
   localparam int BIT_TEMP  = 4;
   localparam int BIT_HDW   = 5;
   localparam int BIT_USRA  = 6;
   localparam int BIT_USRB  = 7;
   localparam int ALARM_W   = 8;
   localparam logic [7:0] DEV_ADDR_STD  = 8'h18;
   localparam logic [7:0] ALARM_RST     = 8'h00;
   // Command bits that clear latched alarms
   localparam logic [7:0] CMD_CLR_MASK  = 8'hcb;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLK_HZ         = 200000000;
   localparam int     STALL_SEC_MIN  = 1;
   localparam int     STALL_SEC_MAX  = 5;
   localparam longint STALL_CYC_DFLT = CLK_HZ * STALL_SEC_MIN;
   localparam int     TMR_W          = 32;
   // Bus operation codes
   typedef enum logic [2:0] {
      OP_NONE   = 3'h0,
      OP_SENSE  = 3'h1,
      OP_READ   = 3'h2,
      OP_WRITE  = 3'h3,
      OP_CMD    = 3'h4,
      OP_ACK    = 3'h5
   } bus_op_type;
endpackage

// [core/alarm_addr_match.sv]
module alarm_addr_match
   import alarm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Address
   input  wire logic [7:0] dev_switch,
   input  wire logic [7:0] bus_addr,
   input  wire logic       bus_strobe,
   // Result
   output logic            selected
);
   typedef struct packed {
      logic [7:0] addr;
   } st_type;
   st_type s_r, s_nxt;
   // ------------------------------------------------------------
   // Capture switches each cycle
   // ------------------------------------------------------------
   always_comb begin
      s_nxt      = s_r;
      s_nxt.addr = dev_switch;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{addr: DEV_ADDR_STD};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign selected = bus_strobe && (bus_addr == s_r.addr);
endmodule // alarm_addr_match

// [core/stall_timer.sv]
module stall_timer
   import alarm_pkg::*;
#(
   parameter logic [TMR_W-1:0] PERIOD = TMR_W'(STALL_CYC_DFLT)
)(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Control
   input  wire logic restart,
   input  wire logic hold,
   // Event
   output logic      expire
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             fired;
   } st_type;
   st_type s_r, s_nxt;
   // ------------------------------------------------------------
   // Count; expire once per run until restarted
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (hold || restart) begin
         s_nxt.cnt   = '0;
         s_nxt.fired = 1'b0;
      end else if (!s_r.fired) begin
         if (s_r.cnt == PERIOD - TMR_W'(1)) begin
            s_nxt.fired = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + TMR_W'(1);
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign expire = !hold && !restart && !s_r.fired && (s_r.cnt == PERIOD - TMR_W'(1));
endmodule // stall_timer

// [core/system_alarm_stall_monitor.sv]
// Operation
// - Power loss alarm sets on detector failure or hardware initialization.
// - Watchdog timeout alarm sets when the stall timer expires, except during hardware initialization.
// - Memory check alarm sets on parity error input.
// - Overtemperature alarm sets on temperature sensor input.
// - Data write with bit 6 set sets user alarm a.
// - Data write with bit 7 set sets user alarm b.
// - Each alarm sets its register bit and lights its lamp.
// - Device answers bus address from eight switches, standard 18 hex.
// - Timer expiry sets status bit 1 and interrupt queue flip-flop.
// - Stall period adjustable one to five seconds by parameter.
// - Command byte with bit 1 set restarts the stall timer.
// - Acknowledge clears queue and status bit 1, timer not restarted.
// - Stall disable holds timer and queue reset, lockout lamp, status bit 2.
// - Bit 5 is OR of power, stall, lockout and parity bits.
// - Three selects add temperature or user alarms to hardware lamp and hardware relay only.
// - Status byte bit 0 power through bit 7 user alarm b.
// - Each relay output follows its lamp, so the hardware relay also takes the three selects.
module system_alarm_stall_monitor
   import alarm_pkg::*;
#(
   parameter logic [TMR_W-1:0] STALL_CYCLES = TMR_W'(STALL_CYC_DFLT)
)(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Multiplexer bus
   input  wire logic [7:0] bus_addr,
   input  wire logic       bus_strobe,
   input  wire bus_op_type bus_op,
   input  wire logic [7:0] bus_wdata,
   output logic [7:0]      bus_rdata,
   output logic            bus_sel,
   output logic            irq_req,
   // Switches and configuration
   input  wire logic [7:0] dev_switch,
   input  wire logic       stall_disable,
   input  wire logic       hdw_sel_temp,
   input  wire logic       hdw_sel_usra,
   input  wire logic       hdw_sel_usrb,
   // Alarm sources
   input  wire logic       power_fail_in,
   input  wire logic       hw_init,
   input  wire logic       parity_err_in,
   input  wire logic       overtemp_in,
   // Indications
   output logic [7:0]      alarm_lamp,
   output logic [7:0]      relay_drv
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] latch;
      logic       queue;
      logic [7:0] rdata;
      logic [7:0] lamp;
   } st_type;
   st_type s_r, s_nxt;

   logic sel;
   logic expire;
   logic restart;
   logic do_cmd;
   logic do_write;
   logic do_ack;
   logic do_stat;

   // Returns the derived hardware summary for a latch image
   function automatic logic hdw_of(input logic [7:0] a);
      return a[BIT_PWR] | a[BIT_WDT] | a[BIT_LOCK] | a[BIT_MEM];
   endfunction

   // ------------------------------------------------------------
   // Address decode and timer
   // ------------------------------------------------------------
   alarm_addr_match u_addr (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .dev_switch (dev_switch),
      .bus_addr   (bus_addr),
      .bus_strobe (bus_strobe),
      .selected   (sel)
   );

   assign do_cmd   = sel && (bus_op == OP_CMD);
   assign do_write = sel && (bus_op == OP_WRITE);
   assign do_ack   = sel && (bus_op == OP_ACK);
   assign do_stat  = sel && ((bus_op == OP_SENSE) || (bus_op == OP_READ));
   assign restart  = do_cmd && bus_wdata[BIT_WDT];

   stall_timer #(.PERIOD(STALL_CYCLES)) u_tmr (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .restart (restart),
      .hold    (stall_disable),
      .expire  (expire)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] clr;
      logic [7:0] set;
      clr   = '0;
      set   = '0;
      s_nxt = s_r;
      // Clears from command byte and acknowledge
      if (do_cmd) begin
         clr = bus_wdata & CMD_CLR_MASK;
      end
      if (do_ack) begin
         clr[BIT_WDT] = 1'b1;
      end
      // Event sets; set beats clear
      set[BIT_PWR]  = power_fail_in | hw_init;
      set[BIT_WDT]  = expire;
      set[BIT_MEM]  = parity_err_in;
      set[BIT_USRA] = do_write & bus_wdata[BIT_USRA];
      set[BIT_USRB] = do_write & bus_wdata[BIT_USRB];
      s_nxt.latch = (s_r.latch & ~clr) | set;
      if (hw_init) begin
         s_nxt.latch = ALARM_RST;
         s_nxt.latch[BIT_PWR] = 1'b1;
      end
      // Live bits
      s_nxt.latch[BIT_LOCK] = stall_disable;
      s_nxt.latch[BIT_TEMP] = overtemp_in;
      s_nxt.latch[BIT_HDW]  = hdw_of(s_nxt.latch);
      // Interrupt queue
      if (stall_disable || hw_init) begin
         s_nxt.queue = 1'b0;
      end else if (expire) begin
         s_nxt.queue = 1'b1;
      end else if (do_ack) begin
         s_nxt.queue = 1'b0;
      end
      // Status byte capture
      if (do_stat) begin
         s_nxt.rdata = s_r.latch;
      end
      // Lamps follow the register; hardware lamp takes the options
      s_nxt.lamp = s_nxt.latch;
      s_nxt.lamp[BIT_HDW] = s_nxt.latch[BIT_HDW]
                          | (hdw_sel_temp & s_nxt.latch[BIT_TEMP])
                          | (hdw_sel_usra & s_nxt.latch[BIT_USRA])
                          | (hdw_sel_usrb & s_nxt.latch[BIT_USRB]);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign bus_rdata  = s_r.rdata;
   assign bus_sel    = sel;
   assign irq_req    = s_r.queue;
   assign alarm_lamp = s_r.lamp;
   assign relay_drv  = s_r.lamp;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_expire;
      expire && !stall_disable && !hw_init;
   endsequence

   chk_pwr_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (power_fail_in || hw_init) |=> s_r.latch[BIT_PWR])
      else $error("power loss alarm not set");
   chk_wdt_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      seq_expire |=> s_r.latch[BIT_WDT] && irq_req)
      else $error("expiry did not set alarm and queue");
   chk_mem_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (parity_err_in && !hw_init) |=> s_r.latch[BIT_MEM])
      else $error("parity alarm not set");
   chk_temp_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
      overtemp_in |=> alarm_lamp[BIT_TEMP])
      else $error("temperature lamp not lit");
   chk_user_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_write && bus_wdata[BIT_USRA] && !hw_init) |=> relay_drv[BIT_USRA])
      else $error("user alarm a not set");
   chk_userb_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_write && bus_wdata[BIT_USRB] && !hw_init) |=> relay_drv[BIT_USRB])
      else $error("user alarm b not set");
   chk_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_ack && !expire) |=> !irq_req && !s_r.latch[BIT_WDT])
      else $error("acknowledge did not clear queue");
   chk_lock_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      stall_disable [*2] |-> !irq_req && alarm_lamp[BIT_LOCK])
      else $error("lockout not held");
   chk_hdw_sum: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_r.latch[BIT_HDW] == hdw_of(s_r.latch))
      else $error("hardware summary wrong");
   chk_status_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
      do_stat |=> bus_rdata == $past(s_r.latch))
      else $error("status byte wrong");
   chk_restart_tmr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      restart |-> !expire)
      else $error("expiry during restart");

   // ------------------------------------------------------------
   // Further checks
   // ------------------------------------------------------------
   sequence seq_restart_cmd;
      do_cmd && bus_wdata[BIT_WDT];
   endsequence
   sequence seq_expire_then_stat;
      seq_expire ##1 (do_stat && !hw_init);
   endsequence
   sequence seq_ack_clean;
      do_ack && !expire && !hw_init;
   endsequence

   // Hardware initialization
   chk_init_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      hw_init |=> !s_r.latch[BIT_MEM] && !s_r.latch[BIT_WDT] && !irq_req)
      else $error("initialization left alarms set");
   chk_init_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
      hw_init |=> alarm_lamp[BIT_PWR] && relay_drv[BIT_PWR] && alarm_lamp[BIT_HDW])
      else $error("initialization did not light power lamp");

   // Lamps follow the register, relays follow the lamps
   chk_wdt_lamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      seq_expire |=> alarm_lamp[BIT_WDT] && alarm_lamp[BIT_HDW])
      else $error("stall lamp not lit");
   chk_mem_lamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (parity_err_in && !hw_init) |=> alarm_lamp[BIT_MEM] && alarm_lamp[BIT_HDW])
      else $error("parity lamp not lit");
   chk_lamp_mirror: assert property (@(posedge clk_sys) disable iff (!rst_b)
      alarm_lamp[BIT_USRB:BIT_USRA] == s_r.latch[BIT_USRB:BIT_USRA] && alarm_lamp[BIT_TEMP:BIT_PWR] == s_r.latch[BIT_TEMP:BIT_PWR])
      else $error("lamp differs from register");
   chk_relay_lamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      relay_drv == alarm_lamp)
      else $error("relay differs from lamp");
   chk_temp_live: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !overtemp_in |=> !alarm_lamp[BIT_TEMP])
      else $error("temperature lamp stuck");

   // Address decode
   chk_sel_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !bus_strobe |-> !bus_sel)
      else $error("selected without strobe");
   chk_sel_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (bus_strobe && bus_addr == $past(dev_switch) && $past(rst_b)) |-> bus_sel)
      else $error("own address not selected");
   chk_wrong_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (bus_strobe && !bus_sel && !hw_init) |=> $stable(s_r.latch[BIT_USRB:BIT_USRA]))
      else $error("foreign address changed user alarms");

   // Stall timer and queue
   chk_stat_bit1: assert property (@(posedge clk_sys) disable iff (!rst_b)
      seq_expire_then_stat |=> bus_rdata[BIT_WDT])
      else $error("status bit 1 missing after expiry");
   chk_expire_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
      expire |=> !expire)
      else $error("timer expired twice");
   chk_restart_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
      seq_restart_cmd |=> !expire)
      else $error("expiry right after restart");
   chk_queue_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (irq_req && !do_ack && !stall_disable && !hw_init) |=> irq_req)
      else $error("queue dropped without acknowledge");
   chk_queue_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(irq_req) |-> $past(expire))
      else $error("queue set without expiry");
   chk_ack_relay: assert property (@(posedge clk_sys) disable iff (!rst_b)
      seq_ack_clean |=> !relay_drv[BIT_WDT])
      else $error("acknowledge left stall relay on");

   // Lockout
   chk_lock_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
      stall_disable |=> s_r.latch[BIT_LOCK] && s_r.latch[BIT_HDW])
      else $error("lockout status not set");
   chk_lock_no_exp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      stall_disable |-> !expire)
      else $error("expiry during lockout");
   chk_lock_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !stall_disable |=> !s_r.latch[BIT_LOCK])
      else $error("lockout bit stuck");

   // Hardware lamp options
   chk_opt_temp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($past(hdw_sel_temp) && alarm_lamp[BIT_TEMP]) |-> relay_drv[BIT_HDW])
      else $error("temperature option ignored");
   chk_opt_usra: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($past(hdw_sel_usra) && alarm_lamp[BIT_USRA]) |-> relay_drv[BIT_HDW])
      else $error("user a option ignored");
   chk_opt_usrb: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($past(hdw_sel_usrb) && alarm_lamp[BIT_USRB]) |-> relay_drv[BIT_HDW])
      else $error("user b option ignored");
   chk_hdw_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_stat && !(s_r.latch[BIT_PWR] || s_r.latch[BIT_WDT] || s_r.latch[BIT_LOCK] || s_r.latch[BIT_MEM]))
      |=> !bus_rdata[BIT_HDW])
      else $error("options reached status bit 5");

   // Status byte
   chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !do_stat |=> $stable(bus_rdata))
      else $error("status byte changed unasked");
   chk_pwr_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_stat && s_r.latch[BIT_PWR]) |=> bus_rdata[BIT_PWR])
      else $error("power bit missing from status");

   // Command clears
   chk_clr_pwr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_cmd && bus_wdata[BIT_PWR] && !power_fail_in && !hw_init) |=> !s_r.latch[BIT_PWR])
      else $error("power alarm not cleared");
   chk_clr_mem: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_cmd && bus_wdata[BIT_MEM] && !parity_err_in) |=> !s_r.latch[BIT_MEM])
      else $error("parity alarm not cleared");
   chk_clr_usra: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_cmd && bus_wdata[BIT_USRA]) |=> !s_r.latch[BIT_USRA])
      else $error("user alarm a not cleared");
   chk_clr_usrb: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (do_cmd && bus_wdata[BIT_USRB]) |=> !s_r.latch[BIT_USRB])
      else $error("user alarm b not cleared");

   // Latched bits hold
   chk_hold_pwr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_r.latch[BIT_PWR] && !(do_cmd && bus_wdata[BIT_PWR])) |=> s_r.latch[BIT_PWR])
      else $error("power alarm dropped");
   chk_hold_wdt: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_r.latch[BIT_WDT] && !do_ack && !(do_cmd && bus_wdata[BIT_WDT]) && !hw_init) |=> s_r.latch[BIT_WDT])
      else $error("stall alarm dropped");
   chk_hold_mem: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_r.latch[BIT_MEM] && !(do_cmd && bus_wdata[BIT_MEM]) && !hw_init) |=> s_r.latch[BIT_MEM])
      else $error("parity alarm dropped");
   chk_hold_usra: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_r.latch[BIT_USRA] && !(do_cmd && bus_wdata[BIT_USRA]) && !hw_init) |=> s_r.latch[BIT_USRA])
      else $error("user alarm a dropped");
   chk_hold_usrb: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_r.latch[BIT_USRB] && !(do_cmd && bus_wdata[BIT_USRB]) && !hw_init) |=> s_r.latch[BIT_USRB])
      else $error("user alarm b dropped");
endmodule // system_alarm_stall_monitor

// [bench/cpu_bus_model.sv]
module cpu_bus_model
   import alarm_pkg::*;
(
   // Clock
   input  wire logic       clk_sys,
   // Bus requests
   output logic [7:0]      bus_addr,
   output logic            bus_strobe,
   output bus_op_type      bus_op,
   output logic [7:0]      bus_wdata,
   // Answer
   input  wire logic [7:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      bus_addr   = 8'he7;
      bus_strobe = 1'b0;
      bus_op     = OP_NONE;
      bus_wdata  = 8'h00;
   end

   // One bus operation, strobe high for one cycle, status sampled after
   task automatic issue(input bus_op_type op, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rd);
      @(negedge clk_sys);
      bus_addr   = addr;
      bus_op     = op;
      bus_wdata  = data;
      bus_strobe = 1'b1;
      @(negedge clk_sys);
      bus_strobe = 1'b0;
      bus_op     = OP_NONE;
      bus_addr   = ~addr; // Released lines do not keep old value
      bus_wdata  = ~data;
      @(negedge clk_sys);
      rd = bus_rdata;
   endtask
endmodule // cpu_bus_model

// [bench/system_alarm_stall_monitor_bench.sv]
module system_alarm_stall_monitor_bench
   import alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst_b = 1'b0, stall_disable = 1'b0, hw_init = 1'b0;
   logic hdw_sel_temp = 1'b0, hdw_sel_usra = 1'b0, hdw_sel_usrb = 1'b0;
   logic power_fail_in = 1'b0, parity_err_in = 1'b0, overtemp_in = 1'b0;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, alarm_lamp, relay_drv, rd;
   logic bus_strobe, bus_sel, irq_req;
   logic [7:0] dev_switch = 8'h18;
   bus_op_type bus_op;
   int errors = 0, num_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   system_alarm_stall_monitor #(.STALL_CYCLES(32'd60)) DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr), .bus_strobe(bus_strobe), .bus_op(bus_op),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_sel(bus_sel), .irq_req(irq_req),
      .dev_switch(dev_switch), .stall_disable(stall_disable), .hdw_sel_temp(hdw_sel_temp),
      .hdw_sel_usra(hdw_sel_usra), .hdw_sel_usrb(hdw_sel_usrb), .power_fail_in(power_fail_in),
      .hw_init(hw_init), .parity_err_in(parity_err_in), .overtemp_in(overtemp_in),
      .alarm_lamp(alarm_lamp), .relay_drv(relay_drv));

   cpu_bus_model cpu (
      .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_strobe(bus_strobe), .bus_op(bus_op),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   // Compare tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_irq(input logic exp);
      chk({7'h00, irq_req}, {7'h00, exp}, "irq");
   endtask
   task automatic sense(input logic [7:0] exp);
      cpu.issue(OP_SENSE, 8'h18, 8'h00, rd);
      chk(rd, exp, "status");
   endtask
   task automatic lamps(input logic [7:0] exp);
      chk(alarm_lamp, exp, "lamp");
      chk(relay_drv, exp, "relay");
   endtask
   task automatic cmd(input bus_op_type op, input logic [7:0] a, input logic [7:0] d);
      cpu.issue(op, a, d, rd);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic done(input string name);
      $display("test %s done, mismatches %0d", name, errors);
   endtask

   // Closing report
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Bounded wait for the stall interrupt
   task automatic wait_irq;
      int i;
      for (i = 0; i < 80 && irq_req !== 1'b1; i++)
         @(negedge clk_sys);
      if (irq_req !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: stall interrupt timeout", $time);
         print_verdict();
      end
   endtask

   // Main sequence
   initial begin
      cyc(12);
      rst_b = 1'b1;
      hw_init = 1'b1;
      cyc(1);
      hw_init = 1'b0;
      cyc(1);
      sense(8'h21);
      lamps(8'h21);
      cmd(OP_CMD, 8'h18, 8'h03);
      sense(8'h00);
      done("init_clear");
      wait_irq();
      sense(8'h22);
      lamps(8'h22);
      cmd(OP_ACK, 8'h18, 8'h00);
      chk_irq(1'b0);
      sense(8'h00);
      cyc(30);
      chk_irq(1'b0);
      done("stall");
      stall_disable = 1'b1;
      cmd(OP_CMD, 8'h18, 8'h02);
      sense(8'h24);
      lamps(8'h24);
      cyc(30);
      chk_irq(1'b0);
      stall_disable = 1'b0;
      cmd(OP_CMD, 8'h18, 8'h02);
      sense(8'h00);
      done("lockout");
      parity_err_in = 1'b1;
      cyc(1);
      parity_err_in = 1'b0;
      sense(8'h28);
      overtemp_in = 1'b1;
      cyc(2);
      sense(8'h38);
      cmd(OP_CMD, 8'h18, 8'h0a);
      sense(8'h10);
      hdw_sel_temp = 1'b1;
      cyc(2);
      lamps(8'h30);
      hdw_sel_temp = 1'b0;
      overtemp_in = 1'b0;
      cyc(2);
      sense(8'h00);
      done("parity_temp");
      cmd(OP_WRITE, 8'h18, 8'hc0);
      sense(8'hc0);
      hdw_sel_usra = 1'b1;
      cyc(2);
      lamps(8'he0);
      sense(8'hc0);
      hdw_sel_usra = 1'b0;
      cmd(OP_CMD, 8'h18, 8'hc2);
      sense(8'h00);
      cmd(OP_WRITE, 8'h18, 8'h80);
      hdw_sel_usrb = 1'b1;
      cyc(2);
      lamps(8'ha0);
      sense(8'h80);
      hdw_sel_usrb = 1'b0;
      cmd(OP_CMD, 8'h18, 8'hc2);
      done("user");
      power_fail_in = 1'b1;
      cyc(1);
      power_fail_in = 1'b0;
      sense(8'h21);
      cmd(OP_CMD, 8'h18, 8'h03);
      sense(8'h00);
      done("power");
      cmd(OP_WRITE, 8'h19, 8'h40);
      sense(8'h00);
      done("address");
      print_verdict();
   end
endmodule // system_alarm_stall_monitor_bench
